// ===== bench/load_word_checker.sv
// Concurrent checks on the ports of the word-load unit.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ns
module load_word_checker
   import load_word_pkg::*;
#(
   parameter int ADDR_W = 64
)(
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire logic              is_64bit,
   input wire logic              insn_valid,
   input wire logic              insn_ready,
   input wire logic [31:0]       insn,
   input wire logic [ADDR_W-1:0] base_value,
   input wire logic              mem_req,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_ack,
   input wire logic              target_we,
   input wire logic [4:0]        target_sel,
   input wire logic              base_we,
   input wire logic [4:0]        base_sel,
   input wire logic [ADDR_W-1:0] base_data,
   input wire logic              reserve_set,
   input wire logic [ADDR_W-1:0] reserve_addr,
   input wire logic              xer_we,
   input wire logic              cr0_we,
   input wire logic              invalid_form,
   input wire logic              illegal_insn,
   input wire logic              fault_taken
);
   // ====================================================================
   // Helpers
   logic              take;
   logic              ext;
   logic [ADDR_W-1:0] disp_ea;
   assign take    = insn_valid && insn_ready;
   assign ext     = insn[31:26] == OP_EXTENDED;
   assign disp_ea = base_value + {{(ADDR_W-16){insn[15]}}, insn[15:0]};
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ====================================================================
   // Checks
   hold_addr_a: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("address moved");
   ack_result_a: assert property (
      mem_req && mem_ack |=> !mem_req && (target_we != fault_taken)) else $error("no result");
   fault_quiet_a: assert property (
      fault_taken |-> !(target_we || base_we || reserve_set)) else $error("write on fault");
   flags_still_a: assert property (
      !(xer_we || cr0_we)) else $error("flag write");
   illegal_trap_a: assert property (
      take && ext && !is_64bit && (insn[10:1] == XO_ALG_UPDATE || insn[10:1] == XO_ALG_INDEXED)
      |=> illegal_insn && !mem_req) else $error("no illegal trap");
   invalid_trap_a: assert property (
      take && ext && is_64bit && insn[10:1] == XO_ALG_UPDATE
      && (insn[20:16] == ZERO_FIELD || insn[20:16] == insn[25:21])
      |=> invalid_form && !mem_req) else $error("no invalid trap");
   disp_addr_a: assert property (
      take && insn[31:26] == OP_DISP_LOAD && insn[20:16] != ZERO_FIELD
      |=> mem_addr == $past(disp_ea)) else $error("bad displacement address");
   base_update_a: assert property (
      base_we |-> target_we && base_data == $past(mem_addr) && base_sel != ZERO_FIELD
      && base_sel != target_sel) else $error("bad base update");
   reserve_addr_a: assert property (
      reserve_set |-> target_we && reserve_addr == $past(mem_addr)) else $error("bad reserve");
   cover property (base_we);
   cover property (reserve_set);
   cover property (fault_taken);
   cover property (illegal_insn);
endmodule

bind load_word_exec_unit load_word_checker #(.ADDR_W(ADDR_W)) i_load_word_checker (
   .sys_clk, .reset, .is_64bit, .insn_valid, .insn_ready, .insn, .base_value, .mem_req,
   .mem_addr, .mem_ack, .target_we, .target_sel, .base_we, .base_sel, .base_data,
   .reserve_set, .reserve_addr, .xer_we, .cr0_we, .invalid_form, .illegal_insn, .fault_taken
);

// ===== bench/storage_model.sv
// Storage access path that answers the word-load unit after a set stall.
// Assumes the unit holds mem_req and mem_addr until the acknowledge edge.
`timescale 1ns/1ns
module storage_model (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        mem_req,
   input  wire logic [31:0] word,
   input  wire logic [3:0]  stall,
   input  wire logic        fault,
   output logic             mem_ack,
   output logic [31:0]      mem_data,
   output logic             mem_fault
);
   logic [3:0] wait_count;
   // ====================================================================
   // Answer
   // Outside the answer cycle data and fault churn, so nothing stale passes.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_ack    <= 1'b0;
         mem_data   <= 32'h0;
         mem_fault  <= 1'b0;
         wait_count <= 4'h0;
      end else if (mem_req && !mem_ack && wait_count >= stall) begin
         mem_ack    <= 1'b1;
         mem_data   <= word;
         mem_fault  <= fault;
         wait_count <= 4'h0;
      end else begin
         mem_ack    <= 1'b0;
         mem_data   <= {mem_data[30:0], ~mem_data[31]};
         mem_fault  <= ~mem_fault;
         wait_count <= (mem_req && !mem_ack) ? wait_count + 4'h1 : 4'h0;
      end
   end
endmodule

// ===== bench/test_load_word_exec_unit.sv
// Self-checking bench for the word-load unit with a storage model.
// Assumes the package, the design, the checker and the model compile first.
`timescale 1ns/1ns
module test_load_word_exec_unit;
   import load_word_pkg::*;
   logic        sys_clk, reset, is_64bit, insn_valid, insn_ready, mem_req, mem_ack;
   logic        mem_fault, target_we, base_we, reserve_set, xer_we, cr0_we, fault;
   logic        invalid_form, illegal_insn, fault_taken;
   logic [3:0]  stall;
   logic [4:0]  target_sel, base_sel;
   logic [31:0] insn, mem_data, word;
   logic [63:0] base_value, index_value, mem_addr, target_data, base_data, reserve_addr;
   int          bad_count = 0;
   int          cmp_count = 0;
   load_word_exec_unit #(.ADDR_W(64)) i_load_word_exec_unit (
      .sys_clk, .reset, .is_64bit, .insn_valid, .insn_ready, .insn, .base_value,
      .index_value, .mem_req, .mem_addr, .mem_ack, .mem_data, .mem_fault, .target_we,
      .target_sel, .target_data, .base_we, .base_sel, .base_data, .reserve_set,
      .reserve_addr, .xer_we, .cr0_we, .invalid_form, .illegal_insn, .fault_taken);
   storage_model i_storage_model (
      .sys_clk, .reset, .mem_req, .word, .stall, .fault, .mem_ack, .mem_data, .mem_fault);
   // ====================================================================
   // Tasks
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [31:0] mk(input int k);
      logic [31:0] r;
      logic [9:0]  xo [4];
      xo = '{XO_ALG_UPDATE, XO_ALG_INDEXED, XO_REVERSED, XO_RESERVE};
      r = $urandom;
      // Few register numbers, so base zero and base equal target turn up often.
      r[20:16] = 5'($urandom_range(3));
      r[25:21] = 5'($urandom_range(3));
      r[31:26] = k < 4 ? OP_EXTENDED : (k == 4 ? OP_DISP_LOAD : OP_DISP_UPDATE);
      if (k < 4) begin
         r[10:1] = xo[k];
         r[0]    = k >= 2;
      end
      return r;
   endfunction
   task automatic run(input logic [31:0] ins, input logic s64, input logic f);
      logic [9:0]  xo;
      logic [4:0]  rt, ra;
      logic [63:0] b, x, d, ea, w;
      logic        ext, alg, upd, ill, inv, bup, rsv;
      xo  = ins[10:1];
      rt  = ins[25:21];
      ra  = ins[20:16];
      ext = ins[31:26] == OP_EXTENDED;
      b   = {$urandom, $urandom};
      x   = {$urandom, $urandom};
      d   = {{48{ins[15]}}, ins[15:0]};
      alg = ext && (xo == XO_ALG_UPDATE || xo == XO_ALG_INDEXED);
      upd = ins[31:26] == OP_DISP_UPDATE || (ext && xo == XO_ALG_UPDATE);
      ill = alg && !s64;
      inv = !ill && ext && xo == XO_ALG_UPDATE && (ra == 0 || ra == rt);
      bup = upd && !f && ra != 0 && ra != rt;
      rsv = ext && xo == XO_RESERVE && !f;
      if (ext)
         ea = (ra == 0 && xo != XO_ALG_UPDATE) ? x : b + x;
      else
         ea = ra == 0 ? d : b + d;
      @(posedge sys_clk);
      insn        <= ins;
      insn_valid  <= 1'b1;
      is_64bit    <= s64;
      base_value  <= b;
      index_value <= x;
      word        <= $urandom;
      stall       <= 4'($urandom_range(3));
      fault       <= f;
      @(posedge sys_clk);
      insn_valid <= 1'b0;
      #1;
      w = alg ? {{32{word[31]}}, word} : {32'h0, word};
      if (ext && xo == XO_REVERSED)
         w = {32'h0, word[7:0], word[15:8], word[23:16], word[31:24]};
      cmp(illegal_insn, ill, "illegal");
      cmp(invalid_form, inv, "invalid");
      cmp(mem_req, !(ill || inv), "request");
      if (ill || inv)
         return;
      cmp(mem_addr, ea, "address");
      for (int i = 0; i < 40 && target_we !== 1'b1 && fault_taken !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      cmp(fault_taken, f, "fault");
      cmp(target_we, !f, "target write");
      cmp(base_we, bup, "base write");
      cmp(reserve_set, rsv, "reserve");
      cmp({xer_we, cr0_we}, 0, "flags");
      if (f)
         return;
      cmp(target_sel, rt, "target register");
      cmp(target_data, w, "target data");
      if (bup) begin
         cmp(base_sel, ra, "base register");
         cmp(base_data, ea, "base data");
      end
      if (rsv)
         cmp(reserve_addr, ea, "reserve address");
   endtask
   // ====================================================================
   // Clock, watchdog and tests
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #(5000 * 100);
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      finish_test();
   end
   initial begin
      {reset, is_64bit} = 2'b11;
      {insn_valid, fault, stall, insn, word, base_value, index_value} = 0;
      void'($urandom(75317));
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 60; i++)
         run(mk(i % 6), 1'b1, 1'b0);
      $display("Test of all classes done");
      for (int i = 0; i < 12; i++)
         run(mk(i % 6), 1'b0, 1'b0);
      $display("Test of 32-bit mode done");
      for (int i = 0; i < 12; i++)
         run(mk(i % 6), 1'b1, 1'b1);
      $display("Test of faults done");
      @(posedge sys_clk);
      insn       <= {OP_EXTENDED, 15'h0, 10'h017, 1'b0};
      insn_valid <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp({insn_ready, mem_req, illegal_insn, invalid_form}, 8, "ignored");
      @(posedge sys_clk);
      insn_valid <= 1'b0;
      $display("Test of unknown opcode done");
      // A lost reservation makes the swap loop load and reserve again.
      for (int t = 0; t < 2; t++)
         run(mk(3), 1'b1, 1'b0);
      $display("Test of swap retry done");
      finish_test();
   end
endmodule

// ===== core/load_decode.sv
// Instruction classifier for the word-load family.
// Assumes a full 32-bit instruction word presented in one cycle.
`timescale 1ns/1ns
module load_decode
   import load_word_pkg::*;
(
   input  wire logic [31:0] insn,
   input  wire logic        is_64bit,
   output op_class_t        op_class,
   output logic             invalid_form,
   output logic             illegal
);
   // ==========================================================================
   // Decode
   // ==========================================================================
   logic [5:0] primary;
   logic [9:0] ext;
   logic [4:0] target_reg_field;
   logic [4:0] base_reg_field;

   assign primary          = insn[PRIMARY_LSB +: 6];
   assign ext              = insn[EXT_LSB +: 10];
   assign target_reg_field = insn[TARGET_LSB +: REG_FIELD_W];
   assign base_reg_field   = insn[BASE_LSB +: REG_FIELD_W];

   always_comb begin
      op_class     = OPC_NONE;
      invalid_form = 1'b0;
      illegal      = 1'b0;
      if (primary == OP_EXTENDED) begin
         if (ext == XO_ALG_UPDATE) begin
            op_class     = OPC_ALG_UPD;
            invalid_form = (base_reg_field == ZERO_FIELD) ||
                           (base_reg_field == target_reg_field);
            illegal      = !is_64bit;
         end else if (ext == XO_ALG_INDEXED) begin
            op_class = OPC_ALG_IDX;
            illegal  = !is_64bit;
         end else if (ext == XO_REVERSED) begin
            op_class = OPC_REVERSED;
         end else if (ext == XO_RESERVE) begin
            op_class = OPC_RESERVE;
         end
      end else if (primary == OP_DISP_LOAD) begin
         op_class = OPC_DISP;
      end else if (primary == OP_DISP_UPDATE) begin
         op_class = OPC_DISP_UPD;
      end
   end
endmodule

// ===== core/load_format.sv
// Result formatter: sign extension, zero extension and byte reversal.
// Assumes the fetched word arrives with storage bit 0 in bit 31.
`timescale 1ns/1ns
module load_format
   import load_word_pkg::*;
(
   input  op_class_t        op_class,
   input  wire logic [31:0] word,
   output logic [63:0]      result
);
   // ==========================================================================
   // Formatting
   // ==========================================================================
   always_comb begin
      case (op_class)
         OPC_ALG_UPD,
         OPC_ALG_IDX:  result = {{32{word[31]}}, word};
         OPC_REVERSED: result = {32'h00000000, word[7:0], word[15:8],
                                 word[23:16], word[31:24]};
         default:      result = {32'h00000000, word};
      endcase
   end
endmodule

// ===== core/load_word_exec_unit.sv
// Decode and execute unit for the fixed-point word-load family.
// Assumes a register file that supplies base and index values with the
// instruction, and a storage path that answers each request once.
`timescale 1ns/1ns

module load_word_exec_unit
   import load_word_pkg::*;
#(
   parameter int ADDR_W = 64
)(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              is_64bit,
   input  wire logic              insn_valid,
   output logic                   insn_ready,
   input  wire logic [31:0]       insn,
   input  wire logic [ADDR_W-1:0] base_value,
   input  wire logic [ADDR_W-1:0] index_value,
   output logic                   mem_req,
   output logic [ADDR_W-1:0]      mem_addr,
   input  wire logic              mem_ack,
   input  wire logic [31:0]       mem_data,
   input  wire logic              mem_fault,
   output logic                   target_we,
   output logic [4:0]             target_sel,
   output logic [63:0]            target_data,
   output logic                   base_we,
   output logic [4:0]             base_sel,
   output logic [ADDR_W-1:0]      base_data,
   output logic                   reserve_set,
   output logic [ADDR_W-1:0]      reserve_addr,
   output logic                   xer_we,
   output logic                   cr0_we,
   output logic                   invalid_form,
   output logic                   illegal_insn,
   output logic                   fault_taken
);
   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [ADDR_W-1:0] form_address(
      input logic [4:0]        base_field,
      input logic [ADDR_W-1:0] base,
      input logic [ADDR_W-1:0] offset
   );
      if (base_field == ZERO_FIELD) begin
         form_address = offset;
      end else begin
         form_address = base + offset;
      end
   endfunction

   // ==========================================================================
   // Decode
   // ==========================================================================
   op_class_t         dec_class;
   logic              dec_invalid;
   logic              dec_illegal;
   logic [4:0]        dec_target;
   logic [4:0]        dec_base;
   logic [ADDR_W-1:0] disp_ext;
   logic [ADDR_W-1:0] disp_addr;
   logic [ADDR_W-1:0] indexed_addr;
   logic [ADDR_W-1:0] dec_addr;
   logic              accept;
   logic              start;

   load_decode u_decode (
      .insn         (insn),
      .is_64bit     (is_64bit),
      .op_class     (dec_class),
      .invalid_form (dec_invalid),
      .illegal      (dec_illegal)
   );

   assign dec_target   = insn[TARGET_LSB +: REG_FIELD_W];
   assign dec_base     = insn[BASE_LSB +: REG_FIELD_W];
   assign disp_ext     = {{(ADDR_W-16){insn[15]}}, insn[15:0]};
   assign disp_addr    = form_address(dec_base, base_value, disp_ext);
   assign indexed_addr = form_address(dec_base, base_value, index_value);

   // Trapped forms are answered at once; only good loads go on to storage.
   assign accept = insn_valid && insn_ready && (dec_class != OPC_NONE);
   assign start  = accept && !dec_illegal && !dec_invalid;

   always_comb begin
      case (dec_class)
         OPC_ALG_UPD:  dec_addr = base_value + index_value;
         OPC_DISP,
         OPC_DISP_UPD: dec_addr = disp_addr;
         default:      dec_addr = indexed_addr;
      endcase
   end

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   exec_state_t       state;
   exec_state_t       next_state;
   logic              answer;
   logic              good;

   assign answer = (state == ST_WAIT) && mem_ack;
   // A faulted answer is turned away here, so no write of any kind follows it.
   assign good   = answer && !mem_fault;

   // The done state keeps insn_ready low in the cycle in which results are written.
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (mem_ack) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // Captured instruction
   // ==========================================================================
   op_class_t         cur_class;
   op_class_t         next_cur_class;
   logic [4:0]        cur_target;
   logic [4:0]        next_cur_target;
   logic [4:0]        cur_base;
   logic [4:0]        next_cur_base;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] next_cur_addr;

   always_comb begin
      next_cur_class  = cur_class;
      next_cur_target = cur_target;
      next_cur_base   = cur_base;
      next_cur_addr   = cur_addr;
      if (start) begin
         next_cur_class  = dec_class;
         next_cur_target = dec_target;
         next_cur_base   = dec_base;
         next_cur_addr   = dec_addr;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cur_class  <= OPC_NONE;
         cur_target <= 5'h00;
         cur_base   <= 5'h00;
         cur_addr   <= '0;
      end else begin
         cur_class  <= next_cur_class;
         cur_target <= next_cur_target;
         cur_base   <= next_cur_base;
         cur_addr   <= next_cur_addr;
      end
   end

   // ==========================================================================
   // Traps
   // ==========================================================================
   logic              next_invalid_form;
   logic              next_illegal_insn;

   // The illegal trap outranks the invalid one when both apply.
   always_comb begin
      next_illegal_insn = accept && dec_illegal;
      next_invalid_form = accept && !dec_illegal && dec_invalid;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         illegal_insn <= 1'b0;
         invalid_form <= 1'b0;
      end else begin
         illegal_insn <= next_illegal_insn;
         invalid_form <= next_invalid_form;
      end
   end

   // ==========================================================================
   // Results
   // ==========================================================================
   logic [63:0]       fmt_result;
   logic              is_update;
   logic              update_allowed;
   logic              next_target_we;
   logic [63:0]       next_target_data;
   logic              next_base_we;
   logic              next_fault_taken;

   // The word is shaped on its way in, so the written value leaves a register.
   load_format u_format (
      .op_class (cur_class),
      .word     (mem_data),
      .result   (fmt_result)
   );

   assign is_update      = (cur_class == OPC_ALG_UPD) || (cur_class == OPC_DISP_UPD);
   // The update forms refuse to touch the base when it would collide with the
   // target; the algebraic one is already trapped as invalid in that case.
   assign update_allowed = (cur_base != ZERO_FIELD) && (cur_base != cur_target);

   always_comb begin
      next_target_we   = good;
      next_target_data = target_data;
      next_base_we     = good && is_update && update_allowed;
      next_fault_taken = answer && mem_fault;
      if (good) begin
         next_target_data = fmt_result;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         target_we   <= 1'b0;
         target_data <= 64'h0000000000000000;
         base_we     <= 1'b0;
         fault_taken <= 1'b0;
      end else begin
         target_we   <= next_target_we;
         target_data <= next_target_data;
         base_we     <= next_base_we;
         fault_taken <= next_fault_taken;
      end
   end

   // ==========================================================================
   // Reservation
   // ==========================================================================
   logic              next_reserve_set;
   logic [ADDR_W-1:0] next_reserve_addr;

   // The address stays after the pulse, so the owner of the conditional store
   // can still match against it later.
   always_comb begin
      next_reserve_set  = good && (cur_class == OPC_RESERVE);
      next_reserve_addr = reserve_addr;
      if (next_reserve_set) begin
         next_reserve_addr = cur_addr;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reserve_set  <= 1'b0;
         reserve_addr <= '0;
      end else begin
         reserve_set  <= next_reserve_set;
         reserve_addr <= next_reserve_addr;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign insn_ready  = (state == ST_IDLE);
   assign mem_req     = (state == ST_WAIT);
   assign mem_addr    = cur_addr;
   assign target_sel  = cur_target;
   assign base_sel    = cur_base;
   assign base_data   = cur_addr;
   // None of these loads records into the exception or condition registers.
   assign xer_we      = 1'b0;
   assign cr0_we      = 1'b0;
endmodule

// ===== core/load_word_pkg.sv
// Constants shared by the word-load execution unit and its helpers.
// Assumes little-endian bit numbering in the instruction word (bit 0 is the LSB).
package load_word_pkg;
   // ==========================================================================
   // Instruction fields
   // ==========================================================================
   localparam int          INSN_W         = 32;
   localparam int          REG_FIELD_W    = 5;
   localparam logic [5:0]  OP_EXTENDED    = 6'h1f;
   localparam logic [5:0]  OP_DISP_LOAD   = 6'h20;
   localparam logic [5:0]  OP_DISP_UPDATE = 6'h21;
   localparam logic [9:0]  XO_ALG_UPDATE  = 10'h175;
   localparam logic [9:0]  XO_ALG_INDEXED = 10'h155;
   localparam logic [9:0]  XO_REVERSED    = 10'h216;
   localparam logic [9:0]  XO_RESERVE     = 10'h014;
   localparam int          PRIMARY_LSB    = 26;
   localparam int          TARGET_LSB     = 21;
   localparam int          BASE_LSB       = 16;
   localparam int          INDEX_LSB      = 11;
   localparam int          EXT_LSB        = 1;
   localparam logic [4:0]  ZERO_FIELD     = 5'h00;

   // ==========================================================================
   // Operation classes
   // ==========================================================================
   typedef enum logic [2:0] {
      OPC_NONE     = 3'b000,
      OPC_ALG_UPD  = 3'b001,
      OPC_ALG_IDX  = 3'b010,
      OPC_REVERSED = 3'b011,
      OPC_DISP     = 3'b100,
      OPC_DISP_UPD = 3'b101,
      OPC_RESERVE  = 3'b110
   } op_class_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } exec_state_t;
endpackage
